/* logic/vsq_params.svh */
`ifndef VSQ_PARAMS_SVH
`define VSQ_PARAMS_SVH
// ****************************************************************
// Timing and level constants
// ****************************************************************
`define VSQ_CLK_NS        10
`define VSQ_SW_PERIOD_NS  2000
`define VSQ_SAMPLES       6
`define VSQ_HALF_SAMPLES  3
`define VSQ_SS_DELAY_CYC  64
`define VSQ_CYC_PER_VOLT  1280
`define VSQ_UNIT_UV       12500
`define VSQ_COARSE_CYC    640
`define VSQ_OFFSET_UV     100000
`define VSQ_NOLOAD_CYC    2
`define VSQ_NOLOAD_A      6'h3F
`define VSQ_NOLOAD_B      6'h3E
// Derived counts: cycles per 12.5mV unit, units of sense offset
`define VSQ_CYC_PER_UNIT  ((`VSQ_CYC_PER_VOLT * `VSQ_UNIT_UV) / 1000000)
`define VSQ_OFFSET_UNITS  (`VSQ_OFFSET_UV / `VSQ_UNIT_UV)
`define VSQ_OFFSET_CYC    (`VSQ_COARSE_CYC / `VSQ_OFFSET_UNITS)
`endif

/* logic/vsq_pkg.sv */
// ****************************************************************
// Types shared by the sequencer files
// ****************************************************************
package vsq_pkg;
  typedef enum logic [1:0] {
    VSQ_ST_OFF,
    VSQ_ST_DELAY,
    VSQ_ST_RAMP,
    VSQ_ST_RUN
  } vsq_state_t;

  // Overvoltage trip level selection handed to the analog comparator
  typedef enum logic [1:0] {
    VSQ_OV_FIXED,
    VSQ_OV_MAX_OF,
    VSQ_OV_VID_PLUS
  } vsq_ov_lvl_t;
endpackage

/* logic/vsq_timebase.sv */
`timescale 1ns/1ns
`include "vsq_params.svh"
// ****************************************************************
// Switching period time base: six sample ticks per period
// ****************************************************************
module vsq_timebase #(
  parameter int SIXTH_CLKS = 33
) (
  input  wire logic clock,
  input  wire logic nrst,
  output logic      sixth_tick,
  output logic      sw_tick
);
  logic [15:0] div_q;
  logic [2:0]  ph_q;

  // Divider; the period is rounded down to whole sixths of clocks
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_q <= 16'h0000;
    end else if (div_q == 16'(SIXTH_CLKS - 1)) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // Sixth counter within the period
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ph_q <= 3'h0;
    end else if (sixth_tick) begin
      ph_q <= (ph_q == 3'(`VSQ_SAMPLES - 1)) ? 3'h0 : ph_q + 3'h1;
    end
  end

  assign sixth_tick = (div_q == 16'(SIXTH_CLKS - 1));
  assign sw_tick    = sixth_tick && (ph_q == 3'(`VSQ_SAMPLES - 1));
endmodule // vsq_timebase

/* logic/vsq_vid_decode.sv */
`timescale 1ns/1ns
`include "vsq_params.svh"
// ****************************************************************
// Voltage-ID code to target count in 12.5mV units
// ****************************************************************
module vsq_vid_decode (
  input  wire logic [5:0] code,
  output logic      [7:0] target_units,
  output logic            no_load
);
  // Two linear segments: codes 21..63 fall from 128, codes 0..20 from 87
  always_comb begin
    if (code >= 6'h15) begin
      target_units = 8'h95 - {2'b00, code};
    end else begin
      target_units = 8'h57 - {2'b00, code};
    end
    no_load = (code == `VSQ_NOLOAD_A) || (code == `VSQ_NOLOAD_B);
  end
endmodule // vsq_vid_decode

/* logic/vsq_sequencer.sv */
`timescale 1ns/1ns
`include "vsq_params.svh"
// Contract
// - Sample the ID code six times per switching period.
// - On a changed code, wait half a period, then step one 12.5mV unit.
// - If the difference changes during that wait, cancel the step.
// - Beyond one unit apart, step six times per period until equal.
// - In shutdown every phase output is released (high impedance).
// - Stay in shutdown until bias power-on reset reports valid.
// - Stay in shutdown until the threshold enable comparator reports high.
// - Logic-level enable must be high to leave shutdown.
// - Both no-load codes shut down; any other code restarts soft start.
// - After a no-load code wait two cycles before shutdown and trip change.
// - A latched overvoltage is not cleared by cycling ID codes.
// - All enables plus a valid code start soft start at once.
// - Ramp reference from zero; outputs released until it reaches output.
// - 64-cycle delay, then 1280 cycles per volt of ramp.
// - Sense offset of 100mV falls to zero over first 640 ramp cycles.
// - Ramp in 25mV steps for 640 cycles, then 12.5mV steps.
// - After soft start, with output in window, raise the output ok flag.
// - Output ok flag low in shutdown, released only after soft start.
module vsq_sequencer
  import vsq_pkg::*;
#(
  parameter int N_PHASE      = 4,
  parameter int SW_PERIOD_NS = `VSQ_SW_PERIOD_NS
) (
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire logic               por_ok,
  input  wire logic               en_above_thr,
  input  wire logic               logic_level_enable,
  input  wire logic [5:0]         voltage_id_code,
  input  wire logic [7:0]         sense_units,
  input  wire logic               in_window,
  input  wire logic               ov_detect,
  input  wire logic [N_PHASE-1:0] pwm_in,
  output logic      [N_PHASE-1:0] pwm_out,
  output logic      [N_PHASE-1:0] pwm_oe,
  output logic      [7:0]         ref_units,
  output logic      [3:0]         sense_offset_units,
  output vsq_ov_lvl_t             ov_level,
  output logic                    ov_latched,
  output logic                    output_ok_flag
);
  // ****************************************************************
  // Time base and decode
  // ****************************************************************
  localparam int SIXTH_CLKS = SW_PERIOD_NS / (`VSQ_SAMPLES * `VSQ_CLK_NS);

  logic       sixth_tick;
  logic       sw_tick;
  logic [5:0] vid_q;
  logic [7:0] target;
  logic       no_load;

  vsq_timebase #(
    .SIXTH_CLKS (SIXTH_CLKS)
  ) u_timebase (
    .clock      (clock),
    .nrst       (nrst),
    .sixth_tick (sixth_tick),
    .sw_tick    (sw_tick)
  );

  vsq_vid_decode u_decode (
    .code         (vid_q),
    .target_units (target),
    .no_load      (no_load)
  );

  // Code sampled on each sixth of the period, never in between
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      vid_q <= `VSQ_NOLOAD_A;
    end else if (sixth_tick) begin
      vid_q <= voltage_id_code;
    end
  end

  // ****************************************************************
  // Enable gating and overvoltage latch
  // ****************************************************************
  vsq_state_t  state_q;
  logic [7:0]  ref_q;
  logic        enables_ok;
  logic        go;
  logic        noload_off;
  logic [1:0]  nl_cnt_q;

  assign enables_ok = por_ok && en_above_thr && logic_level_enable;
  assign go         = enables_ok && !ov_latched && !no_load;

  // Latch cleared only by dropping an enable; set wins over clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ov_latched <= 1'b0;
    end else if (ov_detect) begin
      ov_latched <= 1'b1;
    end else if (!enables_ok) begin
      ov_latched <= 1'b0;
    end
  end

  // No-load codes take effect on the second switching-period boundary after sampling
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      nl_cnt_q <= 2'h0;
    end else if (!no_load || state_q == VSQ_ST_OFF) begin
      nl_cnt_q <= 2'h0;
    end else if (sw_tick && nl_cnt_q != 2'(`VSQ_NOLOAD_CYC)) begin
      nl_cnt_q <= nl_cnt_q + 2'h1;
    end
  end

  assign noload_off = no_load && (nl_cnt_q == 2'(`VSQ_NOLOAD_CYC));

  // ****************************************************************
  // Soft-start sequence
  // ****************************************************************
  logic [11:0] cyc_q;
  logic [7:0]  offs_div_q;
  logic [3:0]  offs_q;
  logic        coarse;
  logic        ramp_step;
  logic [7:0]  ramp_next;

  assign coarse = (cyc_q < 12'(`VSQ_COARSE_CYC));

  // Coarse steps are two units every two unit periods, fine one unit
  always_comb begin
    ramp_step = 1'b0;
    ramp_next = ref_q;
    if (coarse) begin
      ramp_step = sw_tick && (cyc_q[4:0] == 5'(2 * `VSQ_CYC_PER_UNIT - 1));
      ramp_next = (target - ref_q >= 8'h02) ? ref_q + 8'h02 : target;
    end else begin
      ramp_step = sw_tick && (cyc_q[3:0] == 4'(`VSQ_CYC_PER_UNIT - 1));
      ramp_next = ref_q + 8'h01;
    end
  end

  // Main state: a shutdown cause wins over every other move
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= VSQ_ST_OFF;
    end else if (!enables_ok || ov_latched || noload_off) begin
      state_q <= VSQ_ST_OFF;
    end else begin
      case (state_q)
        VSQ_ST_OFF: begin
          if (go) begin
            state_q <= VSQ_ST_DELAY;
          end
        end
        VSQ_ST_DELAY: begin
          if (sw_tick && cyc_q == 12'(`VSQ_SS_DELAY_CYC - 1)) begin
            state_q <= VSQ_ST_RAMP;
          end
        end
        VSQ_ST_RAMP: begin
          if (ref_q >= target) begin
            state_q <= VSQ_ST_RUN;
          end
        end
        default: begin
          state_q <= VSQ_ST_RUN;
        end
      endcase
    end
  end

  // Cycle counter, restarted at delay end so the ramp counts from zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cyc_q <= 12'h000;
    end else if (state_q == VSQ_ST_OFF) begin
      cyc_q <= 12'h000;
    end else if (state_q == VSQ_ST_DELAY && sw_tick &&
                 cyc_q == 12'(`VSQ_SS_DELAY_CYC - 1)) begin
      cyc_q <= 12'h000;
    end else if (sw_tick && cyc_q != 12'hFFF) begin
      cyc_q <= cyc_q + 12'h001;
    end
  end

  // Sense offset starts full and loses one unit every 80 ramp cycles
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      offs_q     <= 4'h0;
      offs_div_q <= 8'h00;
    end else if (state_q == VSQ_ST_OFF) begin
      offs_q     <= 4'(`VSQ_OFFSET_UNITS);
      offs_div_q <= 8'h00;
    end else if (state_q != VSQ_ST_DELAY && sw_tick && offs_q != 4'h0) begin
      if (offs_div_q == 8'(`VSQ_OFFSET_CYC - 1)) begin
        offs_div_q <= 8'h00;
        offs_q     <= offs_q - 4'h1;
      end else begin
        offs_div_q <= offs_div_q + 8'h01;
      end
    end
  end

  // ****************************************************************
  // On-the-fly code tracking
  // ****************************************************************
  logic signed [8:0] diff;
  logic signed [8:0] snap_q;
  logic              wait_q;
  logic [1:0]        wcnt_q;
  logic              big;
  logic              chase_q;
  logic              fast;

  assign diff = $signed({1'b0, target}) - $signed({1'b0, ref_q});
  assign big  = (diff > 9'sd1) || (diff < -9'sd1);
  assign fast = big || chase_q;

  // A jump keeps stepping every sixth until equal, not stalling at one unit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      chase_q <= 1'b0;
    end else if (state_q != VSQ_ST_RUN || diff == 9'sd0) begin
      chase_q <= 1'b0;
    end else if (big) begin
      chase_q <= 1'b1;
    end
  end

  // Half-period wait tracked in sixths; a moved difference cancels it.
  // The wait opens one sixth after the sample that saw the change, so it
  // ends one count early to keep the step half a period after that sample.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 1'b0;
      wcnt_q <= 2'h0;
      snap_q <= 9'sd0;
    end else if (state_q != VSQ_ST_RUN || diff == 9'sd0 || fast) begin
      wait_q <= 1'b0;
      wcnt_q <= 2'h0;
    end else if (sixth_tick) begin
      if (!wait_q) begin
        wait_q <= 1'b1;
        wcnt_q <= 2'h0;
        snap_q <= diff;
      end else if (diff != snap_q) begin
        wait_q <= 1'b0;
      end else if (wcnt_q == 2'(`VSQ_HALF_SAMPLES - 2)) begin
        wait_q <= 1'b0;
      end else begin
        wcnt_q <= wcnt_q + 2'h1;
      end
    end
  end

  // Reference count: cleared in shutdown, ramped, then tracked
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ref_q <= 8'h00;
    end else if (state_q == VSQ_ST_OFF) begin
      ref_q <= 8'h00;
    end else if (state_q == VSQ_ST_RAMP) begin
      if (ramp_step && ref_q < target) begin
        ref_q <= ramp_next;
      end
    end else if (state_q == VSQ_ST_RUN && sixth_tick && diff != 9'sd0) begin
      if (fast || (wait_q && diff == snap_q && wcnt_q == 2'(`VSQ_HALF_SAMPLES - 2))) begin
        ref_q <= (diff > 9'sd0) ? ref_q + 8'h01 : ref_q - 8'h01;
      end
    end
  end

  // ****************************************************************
  // Phase outputs, trip level and output ok
  // ****************************************************************
  logic drive_q;
  logic ok_q;

  // Phases start driving once the ramp meets the sensed output
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      drive_q <= 1'b0;
    end else if (state_q == VSQ_ST_OFF || state_q == VSQ_ST_DELAY) begin
      drive_q <= 1'b0;
    end else if (ref_q >= sense_units) begin
      drive_q <= 1'b1;
    end
  end

  // Phase data registered, so it trails the enable by one clock
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pwm_out <= '0;
    end else begin
      pwm_out <= drive_q ? pwm_in : '0;
    end
  end

  assign pwm_oe = {N_PHASE{drive_q}};

  // Power good only after a completed ramp and inside the window
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ok_q <= 1'b0;
    end else begin
      ok_q <= (state_q == VSQ_ST_RUN) && in_window;
    end
  end

  assign output_ok_flag = ok_q;

  // Trip level: fixed before enable, after a trip referenced to the code
  always_comb begin
    case (state_q)
      VSQ_ST_OFF:   ov_level = ov_latched ? VSQ_OV_VID_PLUS : VSQ_OV_FIXED;
      VSQ_ST_DELAY: ov_level = VSQ_OV_MAX_OF;
      VSQ_ST_RAMP:  ov_level = VSQ_OV_MAX_OF;
      default:      ov_level = VSQ_OV_VID_PLUS;
    endcase
  end

  assign ref_units          = ref_q;
  assign sense_offset_units = offs_q;
endmodule // vsq_sequencer

/* test/vsq_cpu_model.sv */
`timescale 1ns/1ns
// ****************************************
// Processor side: ID code and logic enable
// ****************************************
module vsq_cpu_model (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       load,
  input  wire logic [5:0] want,
  input  wire logic       en_req,
  output logic      [5:0] voltage_id_code,
  output logic            logic_level_enable
);
  // Code moves only on request; the bench paces requests, so a jump is deliberate
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      voltage_id_code <= 6'h3F;
      logic_level_enable <= 1'b0;
    end else begin
      logic_level_enable <= en_req;
      if (load) begin
        voltage_id_code <= want;
      end
    end
  end
endmodule // vsq_cpu_model

/* test/vsq_seq_properties.sv */
`timescale 1ns/1ns
// ****************************************
// Sequencer port properties
// ****************************************
module vsq_seq_properties
  import vsq_pkg::*;
#(
  parameter int N_PHASE      = 4,
  parameter int SW_PERIOD_NS = 2000
) (
  input wire logic               clock,
  input wire logic               nrst,
  input wire logic               por_ok,
  input wire logic               en_above_thr,
  input wire logic               logic_level_enable,
  input wire logic [5:0]         voltage_id_code,
  input wire logic [7:0]         sense_units,
  input wire logic               in_window,
  input wire logic               ov_detect,
  input wire logic [N_PHASE-1:0] pwm_oe,
  input wire logic [7:0]         ref_units,
  input wire vsq_ov_lvl_t        ov_level,
  input wire logic               ov_latched,
  input wire logic               output_ok_flag
);
  localparam int SIXTH = SW_PERIOD_NS / 60;
  localparam int SWC   = 6 * SIXTH;
  logic       en_all;
  logic [7:0] idle_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  assign en_all = por_ok & en_above_thr & logic_level_enable;
  // Idle cycles with every start condition met; a stuck start grows this
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      idle_q <= 8'h00;
    end else if (en_all && !ov_latched && voltage_id_code < 6'h3E
                 && ov_level == VSQ_OV_FIXED && $stable(voltage_id_code)) begin
      idle_q <= idle_q + 8'h01;
    end else begin
      idle_q <= 8'h00;
    end
  end
  start_prompt_a: assert property (idle_q <= 8'(SIXTH + 2))
    else $error("start held back");
  enable_drop_a: assert property (!en_all && !ov_detect
    |=> ov_level == VSQ_OV_FIXED ##1 !output_ok_flag) else $error("no shutdown");
  shut_quiet_a: assert property ($past(ov_level) == VSQ_OV_FIXED
    && ov_level == VSQ_OV_FIXED |-> pwm_oe == '0 && ref_units == 8'h00) else $error("active off");
  noload_wait_a: assert property (en_all && $past(en_all) && !ov_latched
    && ov_level == VSQ_OV_FIXED && $past(ov_level) != VSQ_OV_FIXED
    |-> $past(voltage_id_code, SWC) >= 6'h3E) else $error("early no-load stop");
  oe_reach_a: assert property ($rose(pwm_oe[0])
    |-> $past(ref_units) >= $past(sense_units)) else $error("drive before reach");
  ramp_step_a: assert property ($past(ov_level) == VSQ_OV_MAX_OF && ov_level == VSQ_OV_MAX_OF
    && $changed(ref_units) |-> ref_units - $past(ref_units) inside {8'h01, 8'h02})
    else $error("bad ramp step");
  track_step_a: assert property ($past(ov_level) == VSQ_OV_VID_PLUS && !ov_latched
    && ov_level == VSQ_OV_VID_PLUS && !$past(ov_latched) && $changed(ref_units)
    |-> (ref_units - $past(ref_units)) inside {8'h01, 8'hFF} ##1 $stable(ref_units)[*2])
    else $error("bad track step");
  ov_hold_a: assert property (ov_latched && en_all |=> ov_latched)
    else $error("latch lost");
  ok_cause_a: assert property (output_ok_flag
    |-> $past(ov_level) == VSQ_OV_VID_PLUS && $past(in_window)) else $error("flag early");
  cover property (ov_level == VSQ_OV_VID_PLUS && output_ok_flag);
  cover property ($rose(ov_latched));
  cover property (ov_level == VSQ_OV_VID_PLUS && $changed(ref_units));
endmodule // vsq_seq_properties

bind vsq_sequencer vsq_seq_properties #(.N_PHASE(N_PHASE), .SW_PERIOD_NS(SW_PERIOD_NS)) u_props (
  .clock(clock), .nrst(nrst), .por_ok(por_ok), .en_above_thr(en_above_thr),
  .logic_level_enable(logic_level_enable), .voltage_id_code(voltage_id_code),
  .sense_units(sense_units), .in_window(in_window), .ov_detect(ov_detect),
  .pwm_oe(pwm_oe), .ref_units(ref_units), .ov_level(ov_level),
  .ov_latched(ov_latched), .output_ok_flag(output_ok_flag));

/* test/vid_enable_softstart_sequencer_tb.sv */
`timescale 1ns/1ns
// ****************************************
// Sequencer bench
// ****************************************
module vid_enable_softstart_sequencer_tb
  import vsq_pkg::*;
;
  logic        clock, nrst, por_ok, en_above_thr, en_req, in_window, ov_detect;
  logic        load, logic_level_enable, ov_latched, output_ok_flag;
  logic [5:0]  voltage_id_code, want;
  logic [7:0]  sense_units, ref_units;
  logic [3:0]  pwm_in, pwm_out, pwm_oe, sense_offset_units, pwm_prev;
  vsq_ov_lvl_t ov_level;
  int          err_total, num_checks, cyc, n, m, t, c;

  // Short switching period: 3 clocks per sixth, 18 per period
  vsq_sequencer #(.SW_PERIOD_NS(180)) u_dut (
    .clock(clock), .nrst(nrst), .por_ok(por_ok), .en_above_thr(en_above_thr),
    .logic_level_enable(logic_level_enable), .voltage_id_code(voltage_id_code),
    .sense_units(sense_units), .in_window(in_window), .ov_detect(ov_detect),
    .pwm_in(pwm_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .ref_units(ref_units),
    .sense_offset_units(sense_offset_units), .ov_level(ov_level),
    .ov_latched(ov_latched), .output_ok_flag(output_ok_flag));
  vsq_cpu_model u_cpu (
    .clock(clock), .nrst(nrst), .load(load), .want(want), .en_req(en_req),
    .voltage_id_code(voltage_id_code), .logic_level_enable(logic_level_enable));

  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Random modulator input and hang guard
  always @(posedge clock) begin
    pwm_in <= 4'($urandom);
    pwm_prev <= pwm_in;
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      results();
    end
  end

  // Target count of an ID code, two linear runs of the code table
  function automatic int units(int k);
    return (k <= 20) ? 87 - k : 149 - k;
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_val(logic [7:0] g, logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_lvl(vsq_ov_lvl_t g, vsq_ov_lvl_t e);
    chk_val(8'(g), 8'(e));
  endtask
  task automatic setc(logic [5:0] v);
    want <= v;
    load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
  endtask
  task automatic wait_lvl(vsq_ov_lvl_t l, int lim);
    n = 0;
    while (ov_level !== l && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic wait_ref(int u, int lim);
    n = 1;
    while (ref_units !== 8'(u) && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask

  // Main sequence
  initial begin
    {nrst, por_ok, en_above_thr, en_req, load, ov_detect} = 6'h00;
    in_window = 1'b1;
    want = 6'h00;
    sense_units = 8'h14;
    void'($urandom(95290));
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    chk_val(pwm_oe, 8'h00);
    chk_val(output_ok_flag, 8'h00);
    c = $urandom_range(17, 2);
    t = units(c);
    setc(6'(c));
    // Each enable missing in turn keeps the block off; the logic enable lags
    // one clock in the processor model, so it drops first to avoid an overlap
    for (int i = 0; i < 3; i++) begin
      en_req <= (i != 0);
      por_ok <= (i != 1);
      en_above_thr <= (i != 2);
      repeat (20) @(posedge clock);
      chk_lvl(ov_level, VSQ_OV_FIXED);
    end
    por_ok <= 1'b1;
    en_above_thr <= 1'b1;
    en_req <= 1'b1;
    wait_lvl(VSQ_OV_MAX_OF, 4);
    chk_lvl(ov_level, VSQ_OV_MAX_OF);
    // Delay, then coarse ramp with full sense offset
    // The coarse ramp moves two units at once, so the first value seen is 2
    wait_ref(2, 3000);
    chk_val(n >= 62 * 18 && n <= 98 * 18, 8'h01);
    chk_val(ref_units, 8'h02);
    chk_val(sense_offset_units, 8'h08);
    m = n;
    wait_lvl(VSQ_OV_VID_PLUS, 30000);
    m += n;
    chk_val(m > (64 + 16 * t) * 18 - 36 && m < (64 + 16 * t) * 18 + 36, 8'h01);
    chk_val(ref_units, 8'(t));
    chk_val(sense_offset_units, 8'h00);
    repeat (2) @(posedge clock);
    chk_val(pwm_oe, 8'h0F);
    chk_val(pwm_out, pwm_prev);
    chk_val(output_ok_flag, 8'h01);
    in_window <= 1'b0;
    repeat (3) @(posedge clock);
    chk_val(output_ok_flag, 8'h00);
    in_window <= 1'b1;
    // One-unit step waits half a period
    setc(6'(c - 1));
    wait_ref(t + 1, 40);
    chk_val(n >= 9 && n <= 15, 8'h01);
    // Code seen once then withdrawn: no step
    setc(6'(c - 2));
    repeat (2) @(posedge clock);
    setc(6'(c - 1));
    m = 0;
    repeat (30) begin
      @(posedge clock);
      if (ref_units !== 8'(t + 1)) m++;
    end
    chk_val(8'(m), 8'h00);
    // Three-unit jump tracks one unit per sixth
    setc(6'(c + 2));
    wait_ref(t - 1, 40);
    chk_val(n >= 7 && n <= 24, 8'h01);
    wait_ref(t - 2, 12);
    chk_val(ref_units, 8'(t - 2));
    chk_val(n <= 4, 8'h01);
    // No-load code in run: two periods, then off
    setc(6'h3F);
    repeat (14) @(posedge clock);
    chk_lvl(ov_level, VSQ_OV_VID_PLUS);
    wait_lvl(VSQ_OV_FIXED, 60);
    chk_lvl(ov_level, VSQ_OV_FIXED);
    repeat (2) @(posedge clock);
    chk_val(output_ok_flag, 8'h00);
    chk_val(ref_units, 8'h00);
    chk_val(pwm_oe, 8'h00);
    c = $urandom_range(20, 0);
    setc(6'(c));
    wait_lvl(VSQ_OV_MAX_OF, 8);
    chk_lvl(ov_level, VSQ_OV_MAX_OF);
    // Second no-load code during the start delay
    repeat (100) @(posedge clock);
    setc(6'h3E);
    wait_lvl(VSQ_OV_FIXED, 60);
    chk_lvl(ov_level, VSQ_OV_FIXED);
    setc(6'(c));
    wait_lvl(VSQ_OV_MAX_OF, 8);
    chk_lvl(ov_level, VSQ_OV_MAX_OF);
    // Overvoltage latch survives ID cycling, cleared by enable
    repeat (50) @(posedge clock);
    ov_detect <= 1'b1;
    @(posedge clock);
    ov_detect <= 1'b0;
    setc(6'h3F);
    repeat (60) @(posedge clock);
    setc(6'(c));
    repeat (60) @(posedge clock);
    chk_val(ov_latched, 8'h01);
    chk_lvl(ov_level, VSQ_OV_VID_PLUS);
    en_req <= 1'b0;
    repeat (3) @(posedge clock);
    en_req <= 1'b1;
    wait_lvl(VSQ_OV_MAX_OF, 8);
    chk_val(ov_latched, 8'h00);
    results();
  end
endmodule // vid_enable_softstart_sequencer_tb
